// file: rtl/hbic_pkg.sv
// Constants shared by the host buffer and interrupt controller
package hbic_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int BUF_BITS = 4096;
  localparam int FIFO_DEPTH = BUF_BITS / DATA_W;
  localparam int LVL_W = 8;
  localparam int NUM_UNITS = 5;
  localparam int BURST_LEN = 8;
  localparam int DMA_THRESH = 8;

  // Host word addresses
  localparam logic [11:0] ADR_IN_BUF = 12'h800;
  localparam logic [11:0] ADR_OUT_BUF = 12'h880;
  localparam logic [11:0] ADR_STATUS_CMD = 12'h900;
  localparam logic [11:0] ADR_UNIT_MASK = 12'h902;
  localparam logic [11:0] ADR_IN_CTL = 12'h903;
  localparam logic [11:0] ADR_OUT_CTL = 12'h904;
  localparam logic [11:0] ADR_IN_CNT = 12'h905;
  localparam logic [11:0] ADR_OUT_CNT = 12'h906;

  // Unit bit order, lsb first: public key, random, hash, stream, block
  localparam int MASK_LSB = 0;
  localparam logic [4:0] MASK_RST = 5'h1f;
  // Buffer control fields
  localparam int CTL_OFS_LSB = 0;
  localparam int CTL_OFS_W = 12;
  localparam int CTL_CM_LSB = 16;
  localparam int CTL_CM_W = 8;
  // Status/command fields
  localparam int SC_DEST_LSB = 4;
  localparam int SC_PEND_BIT = 8;
  localparam int SC_ROUTE_A_BIT = 12;
  localparam int SC_ROUTE_B_BIT = 13;
  localparam int SC_IRQ_LSB = 16;
  localparam logic [3:0] DEST_RST = 4'h0;
  localparam logic ROUTE_A_RST = 1'b0;
  localparam logic ROUTE_B_RST = 1'b1;

  localparam logic [3:0] DEST_BLOCK = 4'h8;
  localparam logic [3:0] DEST_STREAM = 4'h9;
  localparam logic [3:0] DEST_HASH = 4'ha;
  localparam logic [3:0] DEST_RANDOM = 4'hb;
  localparam logic [3:0] DEST_PUBKEY = 4'hc;

  typedef enum logic [1:0] {
    HBIC_BUS_IDLE = 2'b01,
    HBIC_BUS_BURST = 2'b10
  } hbic_bus_state_t;
endpackage

// file: rtl/hbic_fifo.sv
// Word buffer of 4096 bits with level report
module hbic_fifo (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] head,
  output logic [7:0] level,
  output logic full,
  output logic empty
);
  logic [31:0] mem [0:hbic_pkg::FIFO_DEPTH-1];
  logic [6:0] wr_ptr_r;
  logic [6:0] rd_ptr_r;
  logic [7:0] level_r;
  logic do_push;
  logic do_pop;

  // Push into a full buffer and pop from an empty one are dropped
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rd_ptr_r];
  assign level = level_r;
  assign full = (level_r == 8'(hbic_pkg::FIFO_DEPTH));
  assign empty = (level_r == 8'h00);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_r <= 7'h00;
      rd_ptr_r <= 7'h00;
      level_r <= 8'h00;
    end else begin
      if (do_push) wr_ptr_r <= wr_ptr_r + 7'h01;
      if (do_pop) rd_ptr_r <= rd_ptr_r + 7'h01;
      if (do_push && !do_pop) level_r <= level_r + 8'h01;
      else if (do_pop && !do_push) level_r <= level_r - 8'h01;
    end
  end
endmodule

// file: rtl/hbic_top.sv
// Host buffer, DMA request and interrupt controller of the coprocessor
// Overview of operation
// RL1: All unit interrupts combine into one active-low host interrupt.
// RL2: A mask bit of 1 blocks that unit's interrupt; 0 passes it.
// RL3: Host interrupt stays asserted while any unmasked unit interrupt pends.
// RL4: All unit interrupts have equal priority, no ordering.
// RL5: Mask bits: block 27, stream 28, hash 29, random 30, public key 31; the code uses bits 4 (block) down to 0 (public key).
// RL6: Input count mask sets words per input block into the unit.
// RL7: Input start offset is the first unit write address; rest derive.
// RL8: Output count mask sets words per output block from the unit.
// RL9: Output start offset is the first unit read address; rest derive.
// RL10: Input word counter counts down per word, stops transfer at zero.
// RL11: Software loads the output word counter with expected word count.
// RL12: Strap pin selects bus style: 0 first style, 1 second style.
// RL13: Eight-word bursts only to the buffers, only in second style.
// RL14: One input and one output buffer of 4096 bits each.
// RL15: Each DMA request routes to either buffer; reset: a input, b output.
// RL16: Input request asserts while at least eight words free there; the code needs eight in the second style, one in the first.
// RL17: Output request stays asserted while eight words wait there; the code needs eight in the second style, one in the first.
// RL18: Single and burst host accesses plus two DMA request outputs.
// RL19: One status/command read shows every unit's interrupt status.
// RL20: Four-bit destination selects the one active unit, 0xxx none.
// RL21: A request negates the cycle after its threshold stops holding.
module hbic_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_style_strap,
  input wire logic host_cs,
  input wire logic host_we,
  input wire logic host_burst,
  input wire logic [11:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_ack,
  output logic host_irq_n,
  output logic dma_request_a_n,
  output logic dma_request_b_n,
  input wire logic [4:0] eu_irq,
  input wire logic eu_out_ready,
  input wire logic [31:0] eu_rdata,
  output logic [4:0] eu_sel,
  output logic eu_wr,
  output logic eu_rd,
  output logic [11:0] eu_addr,
  output logic [31:0] eu_wdata
);
  // Unit address from start offset and index within the block
  function automatic logic [11:0] unit_addr(input logic [11:0] start,
                                            input logic [7:0] idx);
    unit_addr = start + {4'h0, idx};
  endfunction

  // Next index inside a block, wrapping at the count mask
  function automatic logic [7:0] next_idx(input logic [7:0] idx,
                                          input logic [7:0] cmask);
    next_idx = (idx + 8'h01 == cmask) ? 8'h00 : idx + 8'h01;
  endfunction

  // DMA threshold: eight words in the second style, one in the first
  function automatic logic dma_ok(input logic [7:0] amount,
                                  input logic style);
    dma_ok = style ? (amount >= 8'(hbic_pkg::DMA_THRESH))
                   : (amount != 8'h00);
  endfunction

  function automatic logic [4:0] dest_onehot(input logic [3:0] dest);
    case (dest)
      hbic_pkg::DEST_BLOCK: dest_onehot = 5'h10;
      hbic_pkg::DEST_STREAM: dest_onehot = 5'h08;
      hbic_pkg::DEST_HASH: dest_onehot = 5'h04;
      hbic_pkg::DEST_RANDOM: dest_onehot = 5'h02;
      hbic_pkg::DEST_PUBKEY: dest_onehot = 5'h01;
      default: dest_onehot = 5'h00;
    endcase
  endfunction

  logic strap_s1_r;
  logic strap_s2_r;
  logic style_r;
  logic style_done_r;
  logic [4:0] mask_r;
  logic [11:0] in_ofs_r;
  logic [7:0] in_cm_r;
  logic [11:0] out_ofs_r;
  logic [7:0] out_cm_r;
  logic [31:0] in_cnt_r;
  logic [31:0] out_cnt_r;
  logic [3:0] dest_r;
  logic route_a_r;
  logic route_b_r;
  logic [7:0] in_idx_r;
  logic [7:0] out_idx_r;
  hbic_pkg::hbic_bus_state_t bus_st_r;
  hbic_pkg::hbic_bus_state_t bus_st_nxt;
  logic [2:0] beats_r;
  logic [11:0] burst_addr_r;
  logic burst_we_r;
  logic [31:0] host_rdata_r;
  logic host_ack_r;
  logic host_irq_n_r;
  logic dma_a_n_r;
  logic dma_b_n_r;
  logic [4:0] eu_sel_r;
  logic eu_wr_r;
  logic eu_rd_r;
  logic [11:0] eu_addr_r;
  logic [31:0] eu_wdata_r;

  // Host access decode
  logic in_burst;
  logic burst_start;
  logic [11:0] acc_addr;
  logic acc_we;
  logic wr_en;
  logic rd_en;
  logic hit_in_buf;
  logic hit_out_buf;
  logic hit_sc;
  logic hit_mask;
  logic hit_in_ctl;
  logic hit_out_ctl;
  logic hit_in_cnt;
  logic hit_out_cnt;
  logic [31:0] rd_mux;
  logic [31:0] sc_word;
  logic [4:0] irq_live;

  // Transfer decode
  logic unit_active;
  logic in_go;
  logic out_go;
  logic [31:0] in_head;
  logic [7:0] in_level;
  logic in_full;
  logic in_empty;
  logic [31:0] out_head;
  logic [7:0] out_level;
  logic out_full;
  logic out_empty;
  logic in_req;
  logic out_req;

  assign in_burst = (bus_st_r == hbic_pkg::HBIC_BUS_BURST);
  assign acc_addr = in_burst ? burst_addr_r : host_addr;
  assign acc_we = in_burst ? burst_we_r : host_we;
  assign hit_in_buf = (acc_addr == hbic_pkg::ADR_IN_BUF);
  assign hit_out_buf = (acc_addr == hbic_pkg::ADR_OUT_BUF);
  assign burst_start = !in_burst && host_cs && host_burst && style_r &&
                       (hit_in_buf || hit_out_buf); // RL13
  assign wr_en = host_cs && acc_we;
  assign rd_en = host_cs && !acc_we;
  assign hit_sc = (acc_addr == hbic_pkg::ADR_STATUS_CMD);
  assign hit_mask = (acc_addr == hbic_pkg::ADR_UNIT_MASK);
  assign hit_in_ctl = (acc_addr == hbic_pkg::ADR_IN_CTL);
  assign hit_out_ctl = (acc_addr == hbic_pkg::ADR_OUT_CTL);
  assign hit_in_cnt = (acc_addr == hbic_pkg::ADR_IN_CNT);
  assign hit_out_cnt = (acc_addr == hbic_pkg::ADR_OUT_CNT);

  // Raw unit levels plus the combined pending flag in one word
  assign irq_live = eu_irq & ~mask_r; // RL2 RL4
  always_comb begin
    sc_word = 32'h0000_0000;
    sc_word[hbic_pkg::SC_IRQ_LSB +: hbic_pkg::NUM_UNITS] = eu_irq; // RL19
    sc_word[hbic_pkg::SC_PEND_BIT] = |irq_live;
    sc_word[hbic_pkg::SC_DEST_LSB +: 4] = dest_r;
    sc_word[hbic_pkg::SC_ROUTE_A_BIT] = route_a_r;
    sc_word[hbic_pkg::SC_ROUTE_B_BIT] = route_b_r;
  end

  // Reserved bits and unmapped addresses read as zero
  always_comb begin
    if (hit_out_buf) begin
      rd_mux = out_empty ? 32'h0000_0000 : out_head;
    end else if (hit_sc) begin
      rd_mux = sc_word;
    end else if (hit_mask) begin
      rd_mux = {27'h0, mask_r};
    end else if (hit_in_ctl) begin
      rd_mux = {8'h00, in_cm_r, 4'h0, in_ofs_r};
    end else if (hit_out_ctl) begin
      rd_mux = {8'h00, out_cm_r, 4'h0, out_ofs_r};
    end else if (hit_in_cnt) begin
      rd_mux = in_cnt_r;
    end else if (hit_out_cnt) begin
      rd_mux = out_cnt_r;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Only one unit sees buffer traffic at a time
  assign unit_active = (dest_onehot(dest_r) != 5'h00); // RL20
  assign in_go = unit_active && (in_cnt_r != 32'h0) && !in_empty; // RL10
  // Reads alternate with a gap so a returning word always has room
  assign out_go = unit_active && !in_go && (out_cnt_r != 32'h0) &&
                  eu_out_ready && !eu_rd_r && !out_full;

  assign in_req = dma_ok(8'(hbic_pkg::FIFO_DEPTH) - in_level,
                         style_r); // RL16
  assign out_req = dma_ok(out_level, style_r); // RL17

  hbic_fifo u_in_buf ( // RL14
    .clk(clk),
    .sys_rst(sys_rst),
    .push(wr_en && hit_in_buf),
    .push_data(host_wdata),
    .pop(in_go),
    .head(in_head),
    .level(in_level),
    .full(in_full),
    .empty(in_empty)
  );

  hbic_fifo u_out_buf ( // RL14
    .clk(clk),
    .sys_rst(sys_rst),
    .push(eu_rd_r),
    .push_data(eu_rdata),
    .pop(rd_en && hit_out_buf),
    .head(out_head),
    .level(out_level),
    .full(out_full),
    .empty(out_empty)
  );

  // Strap is caught once, after reset releases, through two flops
  always_ff @(posedge clk) begin
    strap_s1_r <= bus_style_strap;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      style_r <= 1'b0;
      style_done_r <= 1'b0;
    end else if (!style_done_r) begin
      style_r <= strap_s2_r; // RL12
      style_done_r <= 1'b1;
    end
  end

  // Burst sequencer: a burst is always eight beats
  always_comb begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      hbic_pkg::HBIC_BUS_IDLE: begin
        if (burst_start) bus_st_nxt = hbic_pkg::HBIC_BUS_BURST;
      end
      hbic_pkg::HBIC_BUS_BURST: begin
        if (host_cs && beats_r == 3'h0) bus_st_nxt = hbic_pkg::HBIC_BUS_IDLE;
      end
      default: bus_st_nxt = hbic_pkg::HBIC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_st_r <= hbic_pkg::HBIC_BUS_IDLE;
      beats_r <= 3'h0;
      burst_addr_r <= 12'h000;
      burst_we_r <= 1'b0;
    end else begin
      bus_st_r <= bus_st_nxt;
      if (burst_start) begin
        beats_r <= 3'(hbic_pkg::BURST_LEN - 2); // RL13
        burst_addr_r <= host_addr;
        burst_we_r <= host_we;
      end else if (in_burst && host_cs && beats_r != 3'h0) begin
        beats_r <= beats_r - 3'h1;
      end
    end
  end

  // Host answer one cycle after each taken beat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_ack_r <= 1'b0;
      host_rdata_r <= 32'h0000_0000;
    end else begin
      host_ack_r <= host_cs; // RL18
      if (rd_en) host_rdata_r <= rd_mux;
    end
  end

  // Software-written registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= hbic_pkg::MASK_RST;
      in_ofs_r <= 12'h000;
      in_cm_r <= 8'h00;
      out_ofs_r <= 12'h000;
      out_cm_r <= 8'h00;
      dest_r <= hbic_pkg::DEST_RST;
      route_a_r <= hbic_pkg::ROUTE_A_RST; // RL15
      route_b_r <= hbic_pkg::ROUTE_B_RST; // RL15
    end else if (wr_en) begin
      if (hit_mask) begin
        mask_r <= host_wdata[hbic_pkg::MASK_LSB +: 5]; // RL5
      end else if (hit_in_ctl) begin
        in_ofs_r <= host_wdata[hbic_pkg::CTL_OFS_LSB +: 12]; // RL7
        in_cm_r <= host_wdata[hbic_pkg::CTL_CM_LSB +: 8]; // RL6
      end else if (hit_out_ctl) begin
        out_ofs_r <= host_wdata[hbic_pkg::CTL_OFS_LSB +: 12]; // RL9
        out_cm_r <= host_wdata[hbic_pkg::CTL_CM_LSB +: 8]; // RL8
      end else if (hit_sc) begin
        dest_r <= host_wdata[hbic_pkg::SC_DEST_LSB +: 4]; // RL20
        route_a_r <= host_wdata[hbic_pkg::SC_ROUTE_A_BIT]; // RL15
        route_b_r <= host_wdata[hbic_pkg::SC_ROUTE_B_BIT]; // RL15
      end
    end
  end

  // Word counters: a host load wins over a same-cycle decrement
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_cnt_r <= 32'h0;
      out_cnt_r <= 32'h0;
    end else begin
      if (wr_en && hit_in_cnt) in_cnt_r <= host_wdata;
      else if (in_go) in_cnt_r <= in_cnt_r - 32'h1; // RL10
      if (wr_en && hit_out_cnt) out_cnt_r <= host_wdata; // RL11
      else if (out_go) out_cnt_r <= out_cnt_r - 32'h1;
    end
  end

  // Block indexes restart whenever their control is rewritten
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_idx_r <= 8'h00;
      out_idx_r <= 8'h00;
    end else begin
      if (wr_en && (hit_in_ctl || hit_in_cnt)) in_idx_r <= 8'h00;
      else if (in_go) in_idx_r <= next_idx(in_idx_r, in_cm_r); // RL6
      if (wr_en && (hit_out_ctl || hit_out_cnt)) out_idx_r <= 8'h00;
      else if (out_go) out_idx_r <= next_idx(out_idx_r, out_cm_r); // RL8
    end
  end

  // Unit side strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eu_sel_r <= 5'h00;
      eu_wr_r <= 1'b0;
      eu_rd_r <= 1'b0;
      eu_addr_r <= 12'h000;
      eu_wdata_r <= 32'h0000_0000;
    end else begin
      eu_sel_r <= dest_onehot(dest_r); // RL20
      eu_wr_r <= in_go;
      eu_rd_r <= out_go;
      if (in_go) begin
        eu_addr_r <= unit_addr(in_ofs_r, in_idx_r); // RL7
        eu_wdata_r <= in_head;
      end else if (out_go) begin
        eu_addr_r <= unit_addr(out_ofs_r, out_idx_r); // RL9
      end
    end
  end

  // Interrupt and DMA request pins, all active low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_irq_n_r <= 1'b1;
      dma_a_n_r <= 1'b1;
      dma_b_n_r <= 1'b1;
    end else begin
      host_irq_n_r <= ~(|irq_live); // RL1 RL3
      dma_a_n_r <= ~(route_a_r ? out_req : in_req); // RL15 RL21
      dma_b_n_r <= ~(route_b_r ? out_req : in_req); // RL15 RL21
    end
  end

  assign host_rdata = host_rdata_r;
  assign host_ack = host_ack_r;
  assign host_irq_n = host_irq_n_r;
  assign dma_request_a_n = dma_a_n_r;
  assign dma_request_b_n = dma_b_n_r;
  assign eu_sel = eu_sel_r;
  assign eu_wr = eu_wr_r;
  assign eu_rd = eu_rd_r;
  assign eu_addr = eu_addr_r;
  assign eu_wdata = eu_wdata_r;
endmodule

// file: tb/hbic_top_monitor.sv
// Port-level checks of the host buffer and interrupt controller
module hbic_top_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_cs,
  input wire logic [31:0] host_rdata,
  input wire logic host_ack,
  input wire logic host_irq_n,
  input wire logic dma_request_a_n,
  input wire logic dma_request_b_n,
  input wire logic [4:0] eu_irq,
  input wire logic eu_out_ready,
  input wire logic [4:0] eu_sel,
  input wire logic eu_wr,
  input wire logic eu_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_ack_taken;
    host_cs |=> host_ack;
  endproperty
  property p_ack_idle;
    !host_cs |=> !host_ack;
  endproperty
  property p_rdata_hold;
    !host_ack |-> $stable(host_rdata);
  endproperty
  property p_irq_quiet;
    eu_irq == 5'h00 |=> host_irq_n;
  endproperty
  property p_rd_gap;
    eu_rd |=> !eu_rd;
  endproperty
  property p_rd_ready;
    eu_rd |-> $past(eu_out_ready);
  endproperty
  property p_sel_single;
    $onehot0(eu_sel);
  endproperty
  property p_wr_sel;
    eu_wr |-> eu_sel != 5'h00 && !eu_rd;
  endproperty
  // Reset must win even though every other check is disabled then
  property p_rst_out;
    disable iff (1'b0)
    sys_rst |=> host_irq_n && dma_request_a_n && dma_request_b_n &&
      !host_ack && !eu_wr && !eu_rd;
  endproperty

  a_ack_taken: assert property (p_ack_taken)
    else $error("no ack after access");
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack without access");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without ack");
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("host interrupt with no unit interrupt");
  a_rd_gap: assert property (p_rd_gap)
    else $error("unit reads back to back");
  a_rd_ready: assert property (p_rd_ready)
    else $error("unit read without ready");
  a_sel_single: assert property (p_sel_single)
    else $error("more than one unit selected");
  a_wr_sel: assert property (p_wr_sel)
    else $error("unit write without single selected unit");
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");

  c_burst: cover property (host_ack [*8]);
  c_wr_pair: cover property (eu_wr ##1 eu_wr);
  c_rd: cover property (eu_rd);
  c_irq: cover property (!host_irq_n);
endmodule

bind hbic_top hbic_top_monitor mon_u (
  .clk, .sys_rst, .host_cs, .host_rdata, .host_ack, .host_irq_n,
  .dma_request_a_n, .dma_request_b_n, .eu_irq, .eu_out_ready,
  .eu_sel, .eu_wr, .eu_rd
);

// file: tb/hbic_eu_model.sv
// Execution unit stand-in: logs written words, serves read words
module hbic_eu_model (
  input wire logic clk,
  input wire logic [4:0] eu_sel,
  input wire logic eu_wr,
  input wire logic eu_rd,
  input wire logic [11:0] eu_addr,
  input wire logic [31:0] eu_wdata,
  output logic [31:0] eu_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] wr_addr [0:15];
  logic [31:0] wr_data [0:15];
  int wr_cnt = 0;

  // Inverted outside a read so stale data never looks valid
  assign eu_rdata = eu_rd ? {20'ha5a5a, eu_addr} : ~{20'ha5a5a, eu_addr};

  always @(posedge clk) begin
    if (eu_wr && eu_sel != 5'h00 && wr_cnt < 16) begin
      wr_addr[wr_cnt] <= eu_addr;
      wr_data[wr_cnt] <= eu_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

// file: tb/testbench.sv
// Scenario bench of the host buffer and interrupt controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic host_cs = 1'b0;
  logic host_we = 1'b0;
  logic host_burst = 1'b0;
  logic bus_style_strap = 1'b1;
  logic [11:0] host_addr = 12'h000;
  logic [31:0] host_wdata = 32'h0;
  logic [4:0] eu_irq = 5'h00;
  logic eu_out_ready = 1'b0;
  logic [31:0] host_rdata, eu_rdata, eu_wdata;
  logic host_ack, host_irq_n, dma_request_a_n, dma_request_b_n;
  logic eu_wr, eu_rd;
  logic [4:0] eu_sel;
  logic [11:0] eu_addr;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  hbic_top dut_u (.clk, .sys_rst, .bus_style_strap, .host_cs,
    .host_we, .host_burst, .host_addr, .host_wdata, .host_rdata,
    .host_ack, .host_irq_n, .dma_request_a_n, .dma_request_b_n, .eu_irq,
    .eu_out_ready, .eu_rdata, .eu_sel, .eu_wr, .eu_rd, .eu_addr,
    .eu_wdata);
  hbic_eu_model eu_u (.clk, .eu_sel, .eu_wr, .eu_rd, .eu_addr,
    .eu_wdata, .eu_rdata);

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic we, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge clk) #1;
    host_cs = 1'b1;
    host_we = we;
    host_addr = a;
    host_wdata = d;
    @(posedge clk) #1;
    host_cs = 1'b0;
    chk({31'h0, host_ack}, 32'h1, "ack");
    if (!we) chk(host_rdata, e, "read");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, e);
  endtask

  // Eight beats, burst flag only on the first; address and direction held for all
  task automatic burst(input logic we);
    @(posedge clk) #1;
    host_cs = 1'b1;
    host_we = we;
    host_burst = 1'b1;
    host_addr = we ? hbic_pkg::ADR_IN_BUF : hbic_pkg::ADR_OUT_BUF;
    for (int i = 0; i < 8; i++) begin
      host_wdata = 32'h100 + i;
      @(posedge clk) #1;
      host_burst = 1'b0;
      chk({31'h0, host_ack}, 32'h1, "burst ack");
      if (!we) chk(host_rdata, 32'ha5a5_a020 + (i % 2), "burst rd");
    end
    host_cs = 1'b0;
  endtask

  task automatic t_reset();
    rd(hbic_pkg::ADR_UNIT_MASK, 32'h1f);
    rd(hbic_pkg::ADR_STATUS_CMD, 32'h2000);
    rd(12'h123, 32'h0);
    chk({31'h0, host_irq_n}, 32'h1, "irq idle");
    chk({31'h0, dma_request_a_n}, 32'h0, "req a");
    chk({31'h0, dma_request_b_n}, 32'h1, "req b");
    $display("reset test done");
  endtask

  task automatic t_irq();
    for (int i = 0; i < 5; i++) begin
      eu_irq = 5'h01 << i;
      tick(2);
      chk({31'h0, host_irq_n}, 32'h1, "masked");
      rd(hbic_pkg::ADR_STATUS_CMD, 32'h2000 | (32'h1 << (16 + i)));
      wr(hbic_pkg::ADR_UNIT_MASK, {27'h0, ~eu_irq});
      tick(2);
      chk({31'h0, host_irq_n}, 32'h0, "unmasked");
      rd(hbic_pkg::ADR_STATUS_CMD, 32'h2100 | (32'h1 << (16 + i)));
      eu_irq = 5'h00;
      tick(2);
      chk({31'h0, host_irq_n}, 32'h1, "serviced");
      wr(hbic_pkg::ADR_UNIT_MASK, 32'h1f);
    end
    wr(hbic_pkg::ADR_UNIT_MASK, 32'h0);
    eu_irq = 5'h11;
    tick(2);
    eu_irq = 5'h01;
    tick(2);
    chk({31'h0, host_irq_n}, 32'h0, "one left");
    eu_irq = 5'h00;
    tick(2);
    chk({31'h0, host_irq_n}, 32'h1, "none left");
    $display("irq test done");
  endtask

  task automatic t_in();
    wr(hbic_pkg::ADR_STATUS_CMD, 32'h2080);
    wr(hbic_pkg::ADR_IN_CTL, 32'h0004_0010);
    chk({27'h0, eu_sel}, 32'h10, "unit select");
    burst(1'b1);
    wr(hbic_pkg::ADR_IN_CNT, 32'h6);
    tick(12);
    chk(32'(eu_u.wr_cnt), 32'h6, "word count");
    for (int i = 0; i < 6; i++) begin
      chk({20'h0, eu_u.wr_addr[i]}, 32'h10 + (i % 4), "addr");
      chk(eu_u.wr_data[i], 32'h100 + i, "data");
    end
    rd(hbic_pkg::ADR_IN_CNT, 32'h0);
    wr(hbic_pkg::ADR_STATUS_CMD, 32'h1080);
    tick(2);
    chk({31'h0, dma_request_a_n}, 32'h1, "swap a");
    chk({31'h0, dma_request_b_n}, 32'h0, "swap b");
    wr(hbic_pkg::ADR_STATUS_CMD, 32'h2080);
    // Two words remain, so fifteen bursts leave six free
    repeat (15) burst(1'b1);
    tick(2);
    chk({31'h0, dma_request_a_n}, 32'h1, "in nearly full");
    wr(hbic_pkg::ADR_IN_CNT, 32'h8);
    tick(12);
    chk({31'h0, dma_request_a_n}, 32'h0, "in space again");
    $display("input test done");
  endtask

  task automatic t_out();
    wr(hbic_pkg::ADR_OUT_CTL, 32'h0002_0020);
    wr(hbic_pkg::ADR_OUT_CNT, 32'h3);
    eu_out_ready = 1'b1;
    tick(12);
    chk({31'h0, dma_request_b_n}, 32'h1, "few stored");
    rd(hbic_pkg::ADR_OUT_BUF, 32'ha5a5_a020);
    rd(hbic_pkg::ADR_OUT_BUF, 32'ha5a5_a021);
    rd(hbic_pkg::ADR_OUT_BUF, 32'ha5a5_a020);
    rd(hbic_pkg::ADR_OUT_BUF, 32'h0);
    wr(hbic_pkg::ADR_OUT_CNT, 32'h8);
    tick(24);
    chk({31'h0, dma_request_b_n}, 32'h0, "eight stored");
    burst(1'b0);
    tick(2);
    chk({31'h0, dma_request_b_n}, 32'h1, "drained");
    eu_out_ready = 1'b0;
    $display("output test done");
  endtask

  // Strap change only counts after a fresh reset
  task automatic t_style();
    bus_style_strap = 1'b0;
    tick(3);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    wr(hbic_pkg::ADR_STATUS_CMD, 32'h2080);
    wr(hbic_pkg::ADR_OUT_CTL, 32'h0001_0030);
    wr(hbic_pkg::ADR_OUT_CNT, 32'h1);
    eu_out_ready = 1'b1;
    tick(4);
    chk({31'h0, dma_request_b_n}, 32'h0, "one stored");
    host_burst = 1'b1;
    rd(hbic_pkg::ADR_OUT_BUF, 32'ha5a5_a030);
    host_burst = 1'b0;
    rd(hbic_pkg::ADR_UNIT_MASK, 32'h1f);
    chk({31'h0, dma_request_b_n}, 32'h1, "none stored");
    eu_out_ready = 1'b0;
    $display("style test done");
  endtask

  task automatic results();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      $display("ERROR %0t run did not finish", $time);
      results();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_irq();
    t_in();
    t_out();
    t_style();
    results();
  end
endmodule
